// >>> logic/sshp_core.v
// host port of the combined serial and scsi controller
// What this block does
// [R1] both units share data bus and strobes
// [R2] register picked by address while selected
// [R3] grant clears dma request, picks data register
// [R4] dma controller uses grant, not address
// [R5] initiator drives ACK, target receives it
// [R6] initiator drives ATN, target only receives
// [R7] BSY driven in either role
// [R8] target drives C/D, true means control
// [R9] auto enable: low pin enables transmitter
// [R10] clear-to-send and clock share one pin
// [R11] chain enable in held active, out unused
// [R12] ready and channel b sync unconnected
// [R13] bus line zero is byte bit zero
// [R14] dma request only in dma mode
// [R15] terminate finishes byte, stops requests
// [R16] grant read is input, write is output
// [R17] target drives I/O, true means to initiator
// [R18] host never selects two units together
`timescale 1ns/10ps
`default_nettype none
`include "sshp_regs.vh"

module sshp_core #(
  parameter SYNC_W = 36
) (
  input  wire        mclk,
  input  wire        srst,
  input  wire        clk_en,
  input  wire        rd_n,
  input  wire        wr_n,
  input  wire [2:0]  addr,
  input  wire        parallel_unit_select_n,
  input  wire        serial_unit_select_n,
  input  wire        dma_grant_n,
  input  wire        transfer_terminate_n,
  input  wire [7:0]  host_data_in,
  output reg  [7:0]  host_data_out,
  output reg         host_data_oe,
  output reg         dma_want,
  input  wire [7:0]  ser_rdata,
  output reg         ser_select,
  output reg         ser_rd,
  output reg         ser_wr,
  output reg  [7:0]  ser_wdata,
  input  wire        chan_a_clear_clock_pin,
  input  wire        chan_b_clear_clock_pin,
  input  wire        chan_a_auto_enable,
  input  wire        chan_b_auto_enable,
  output reg         chan_a_clear,
  output reg         chan_a_clock,
  output reg         chan_b_clear,
  output reg         chan_b_clock,
  output reg         chan_a_tx_enable,
  output reg         chan_b_tx_enable,
  output reg         chain_enable_in,
  input  wire [7:0]  scsi_data_in,
  output reg  [7:0]  scsi_data_out,
  output reg  [7:0]  scsi_data_oe,
  output reg         scsi_parity_out,
  output reg         scsi_parity_oe,
  input  wire [8:0]  scsi_line_in,
  output reg  [8:0]  scsi_line_out,
  output reg  [8:0]  scsi_line_oe
);

  localparam [1:0] S_IDLE  = 2'd0;
  localparam [1:0] S_WAIT  = 2'd1;
  localparam [1:0] S_DRIVE = 2'd2;
  localparam [1:0] S_REL   = 2'd3;

  // ==========================================================
  // two-flop synchronisers for every pin input except clk_en, srst, the two auto enables and the serial read data
  wire [SYNC_W-1:0] raw_in;
  reg  [SYNC_W-1:0] meta_reg;
  reg  [SYNC_W-1:0] sync_reg;
  genvar gi;

  assign raw_in = {rd_n, wr_n, parallel_unit_select_n, serial_unit_select_n, dma_grant_n,
                   transfer_terminate_n, addr, chan_a_clear_clock_pin,
                   chan_b_clear_clock_pin, host_data_in, scsi_data_in, scsi_line_in};

  generate
    for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
      always @(posedge mclk) begin
        if (srst) begin
          meta_reg[gi] <= `SSHP_RST_SYNC;
          sync_reg[gi] <= `SSHP_RST_SYNC;
        end else if (clk_en) begin
          meta_reg[gi] <= raw_in[gi];
          sync_reg[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

  wire       rd_s    = ~sync_reg[35];
  wire       wr_s    = ~sync_reg[34];
  wire       pcs_s   = ~sync_reg[33];
  wire       scs_s   = ~sync_reg[32];
  wire       dma_grant_n_s  = ~sync_reg[31];
  wire       eop_s   = ~sync_reg[30];
  wire [2:0] addr_s  = sync_reg[29:27];
  wire       pin_a_s = sync_reg[26];
  wire       pin_b_s = sync_reg[25];
  wire [7:0] hdin_s  = sync_reg[24:17];
  // active-low bus: asserted lines read as ones, line zero lands in bit 0
  wire [7:0] sdata_s = ~sync_reg[16:9]; // [R13]
  wire [8:0] line_s  = ~sync_reg[8:0];

  // ==========================================================
  // access detection on the shared strobes
  reg  strobe_d_reg;
  wire strobe    = rd_s | wr_s; // [R1]
  wire acc_start = strobe & ~strobe_d_reg;
  wire reg_acc   = acc_start & pcs_s & ~dma_grant_n_s; // [R2]
  wire dma_acc   = acc_start & dma_grant_n_s; // [R4]

  // ==========================================================
  // control registers and handshake state
  reg [7:0] icmd_reg;
  reg [7:0] mode_reg;
  reg [7:0] tcmd_reg;
  reg [7:0] out_byte_reg;
  reg [1:0] state_reg;
  reg       eop_done_reg;
  reg       rd_pend_reg;
  reg [2:0] rd_idx_reg;
  reg       cap_en;

  wire dma_mode = mode_reg[`SSHP_MODE_DMA];
  wire target   = mode_reg[`SSHP_MODE_TARGET];
  wire req_in   = line_s[`SSHP_L_REQ];
  wire ack_in   = line_s[`SSHP_L_ACK];
  wire io_in    = line_s[`SSHP_L_IO];
  // true io means data flows toward the initiator
  wire to_us    = target ? ~tcmd_reg[`SSHP_TCMD_IO] : io_in; // [R17]
  wire [7:0] mem_rdata;

  always @* begin
    cap_en = 1'b0;
    if (state_reg == S_IDLE && !target && dma_mode && !eop_done_reg && req_in) begin
      cap_en = io_in;
    end
    if (state_reg == S_DRIVE && target && ack_in) begin
      cap_en = to_us;
    end
  end

  sshp_regmem #(
    .WIDTH (8),
    .DEPTH (2),
    .AW    (1)
  ) u_mem (
    .mclk    (mclk),
    .clk_en  (clk_en),
    .wr_en   (cap_en),
    .wr_addr (1'b0),
    .wr_data (sdata_s),
    .rd_addr (1'b0),
    .rd_data (mem_rdata)
  );

  always @(posedge mclk) begin
    if (srst) begin
      strobe_d_reg <= 1'b0;
      icmd_reg     <= `SSHP_RST_BYTE;
      mode_reg     <= `SSHP_RST_BYTE;
      tcmd_reg     <= `SSHP_RST_BYTE;
      out_byte_reg <= `SSHP_RST_BYTE;
      state_reg    <= S_IDLE;
      eop_done_reg <= 1'b0;
      dma_want     <= 1'b0;
      rd_pend_reg  <= 1'b0;
      rd_idx_reg   <= 3'h0;
    end else if (clk_en) begin
      strobe_d_reg <= strobe;
      rd_pend_reg  <= (reg_acc | dma_acc) & rd_s;
      // grant read always returns the input data register
      rd_idx_reg   <= dma_acc ? `SSHP_REG_INDATA : addr_s; // [R16]
      if (reg_acc && wr_s) begin
        case (addr_s)
          `SSHP_REG_ICMD:    icmd_reg <= hdin_s;
          `SSHP_REG_MODE:    mode_reg <= hdin_s;
          `SSHP_REG_TCMD:    tcmd_reg <= hdin_s;
          `SSHP_REG_OUTDATA: out_byte_reg <= hdin_s;
          default:           out_byte_reg <= out_byte_reg;
        endcase
      end
      if (dma_acc && wr_s) begin
        out_byte_reg <= hdin_s; // [R16]
      end
      // terminate during a grant still lets this byte finish
      if (dma_acc && eop_s) begin
        eop_done_reg <= 1'b1; // [R15]
      end else if (!dma_mode) begin
        eop_done_reg <= 1'b0;
      end
      if (!dma_mode) begin
        state_reg <= S_IDLE;
        dma_want  <= 1'b0; // [R14]
      end else begin
        case (state_reg)
          S_IDLE: begin
            if (!eop_done_reg && (target || req_in)) begin
              dma_want  <= 1'b1; // [R14]
              state_reg <= S_WAIT;
            end
          end
          S_WAIT: begin
            if (dma_acc) begin
              dma_want  <= 1'b0; // [R3]
              state_reg <= S_DRIVE;
            end
          end
          S_DRIVE: begin
            if (target ? ack_in : ~req_in) begin // [R5]
              state_reg <= target ? S_REL : S_IDLE;
            end
          end
          S_REL: begin
            if (!ack_in) begin
              state_reg <= S_IDLE;
            end
          end
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // scsi line drive, open drain: oe high pulls the line low
  reg [8:0] oe_next;
  reg       data_drive;

  always @* begin
    oe_next    = `SSHP_RST_LINES;
    data_drive = icmd_reg[`SSHP_ICMD_DRIVE] |
                 ((state_reg == S_DRIVE || state_reg == S_REL) & ~to_us);
    oe_next[`SSHP_L_BSY] = icmd_reg[`SSHP_ICMD_BSY]; // [R7]
    oe_next[`SSHP_L_SEL] = icmd_reg[`SSHP_ICMD_SEL];
    oe_next[`SSHP_L_RST] = icmd_reg[`SSHP_ICMD_RST];
    if (target) begin
      oe_next[`SSHP_L_IO]  = tcmd_reg[`SSHP_TCMD_IO]; // [R17]
      oe_next[`SSHP_L_CD]  = tcmd_reg[`SSHP_TCMD_CD]; // [R8]
      oe_next[`SSHP_L_MSG] = tcmd_reg[`SSHP_TCMD_MSG];
      oe_next[`SSHP_L_REQ] = tcmd_reg[`SSHP_TCMD_REQ] | (state_reg == S_DRIVE); // [R5]
    end else begin
      oe_next[`SSHP_L_ATN] = icmd_reg[`SSHP_ICMD_ATN]; // [R6]
      oe_next[`SSHP_L_ACK] = icmd_reg[`SSHP_ICMD_ACK] | (state_reg == S_DRIVE); // [R5]
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      scsi_line_oe    <= `SSHP_RST_LINES;
      scsi_line_out   <= `SSHP_RST_LINES;
      scsi_data_oe    <= `SSHP_RST_BYTE;
      scsi_data_out   <= `SSHP_RST_BYTE;
      scsi_parity_oe  <= 1'b0;
      scsi_parity_out <= 1'b0;
    end else if (clk_en) begin
      scsi_line_oe    <= oe_next;
      scsi_data_oe    <= data_drive ? out_byte_reg : `SSHP_RST_BYTE; // [R13]
      // odd parity: pull parity low when the byte has an even count of ones
      scsi_parity_oe  <= data_drive & ~(^out_byte_reg);
    end
  end

  // ==========================================================
  // host data bus and serial unit pass-through
  reg [7:0] rdata_next;

  always @* begin
    case (rd_idx_reg)
      `SSHP_REG_BUSDATA: rdata_next = sdata_s;
      `SSHP_REG_ICMD:    rdata_next = icmd_reg;
      `SSHP_REG_MODE:    rdata_next = mode_reg;
      `SSHP_REG_TCMD:    rdata_next = tcmd_reg;
      `SSHP_REG_BUSSTAT: rdata_next = line_s[7:0];
      `SSHP_REG_STATUS:  rdata_next = {1'b0, dma_want, 2'b00, eop_done_reg, 1'b0, state_reg};
      `SSHP_REG_INDATA:  rdata_next = mem_rdata;
      default:           rdata_next = out_byte_reg;
    endcase
  end

  always @(posedge mclk) begin
    if (srst) begin
      host_data_out    <= `SSHP_RST_BYTE;
      host_data_oe     <= 1'b0;
      ser_select       <= 1'b0;
      ser_rd           <= 1'b0;
      ser_wr           <= 1'b0;
      ser_wdata        <= `SSHP_RST_BYTE;
      chan_a_clear     <= 1'b1;
      chan_a_clock     <= 1'b1;
      chan_b_clear     <= 1'b1;
      chan_b_clock     <= 1'b1;
      chan_a_tx_enable <= 1'b0;
      chan_b_tx_enable <= 1'b0;
      chain_enable_in  <= 1'b1;
    end else if (clk_en) begin
      // relies on the host never selecting both units at once
      host_data_oe <= rd_s & (scs_s | pcs_s | dma_grant_n_s); // [R18]
      if (scs_s && rd_s) begin
        host_data_out <= ser_rdata; // [R1]
      end else if (rd_pend_reg) begin
        host_data_out <= rdata_next; // [R2]
      end
      ser_select <= scs_s; // [R1]
      ser_rd     <= scs_s & rd_s;
      ser_wr     <= scs_s & wr_s;
      ser_wdata  <= hdin_s;
      chan_a_clear <= pin_a_s; // [R10]
      chan_a_clock <= pin_a_s; // [R10]
      chan_b_clear <= pin_b_s; // [R10]
      chan_b_clock <= pin_b_s; // [R10]
      chan_a_tx_enable <= ~chan_a_auto_enable | ~pin_a_s; // [R9]
      chan_b_tx_enable <= ~chan_b_auto_enable | ~pin_b_s; // [R9]
      // chain output, ready and channel b sync have no port at all
      chain_enable_in <= 1'b1; // [R11] [R12]
    end
  end

endmodule

`default_nettype wire

// >>> logic/sshp_regmem.v
// small byte store for data captured from the scsi bus, registered read
`timescale 1ns/10ps
`default_nettype none

module sshp_regmem #(
  parameter WIDTH = 8,
  parameter DEPTH = 2,
  parameter AW    = 1
) (
  input  wire             mclk,
  input  wire             clk_en,
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [AW-1:0]    rd_addr,
  output reg  [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // ==========================================================
  // storage: no reset, contents read before the first capture are unknown
  always @(posedge mclk) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end

endmodule

`default_nettype wire

// >>> shared/sshp_regs.vh
// register offsets, field positions and reset values of the parallel unit host port
`ifndef SSHP_REGS_VH
`define SSHP_REGS_VH

// ==========================================================
// register index on the three address lines
`define SSHP_REG_BUSDATA  3'h0
`define SSHP_REG_ICMD     3'h1
`define SSHP_REG_MODE     3'h2
`define SSHP_REG_TCMD     3'h3
`define SSHP_REG_BUSSTAT  3'h4
`define SSHP_REG_STATUS   3'h5
`define SSHP_REG_INDATA   3'h6
`define SSHP_REG_OUTDATA  3'h7

// ==========================================================
// initiator command fields
`define SSHP_ICMD_DRIVE   0
`define SSHP_ICMD_ATN     1
`define SSHP_ICMD_SEL     2
`define SSHP_ICMD_BSY     3
`define SSHP_ICMD_ACK     4
`define SSHP_ICMD_RST     7

// mode fields
`define SSHP_MODE_DMA     1
`define SSHP_MODE_TARGET  6

// target command fields
`define SSHP_TCMD_IO      0
`define SSHP_TCMD_CD      1
`define SSHP_TCMD_MSG     2
`define SSHP_TCMD_REQ     3

// status fields
`define SSHP_STAT_WANT    6
`define SSHP_STAT_EOP     3
`define SSHP_STAT_PHASE   0

// ==========================================================
// scsi control line order in the line vectors
`define SSHP_L_REQ        0
`define SSHP_L_ACK        1
`define SSHP_L_ATN        2
`define SSHP_L_BSY        3
`define SSHP_L_CD         4
`define SSHP_L_IO         5
`define SSHP_L_MSG        6
`define SSHP_L_SEL        7
`define SSHP_L_RST        8
`define SSHP_NLINES       9

// ==========================================================
// reset values
`define SSHP_RST_BYTE     8'h00
`define SSHP_RST_LINES    9'h000
`define SSHP_RST_SYNC     1'b1

`endif

// >>> tb/sshp_core_monitor.sv
// port assertions for the scsi host port core
`timescale 1ns/10ps
`default_nettype none
module sshp_mon (
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic       clk_en,
  input wire logic       rd_n,
  input wire logic       parallel_unit_select_n,
  input wire logic       serial_unit_select_n,
  input wire logic       dma_grant_n,
  input wire logic       host_data_oe,
  input wire logic       dma_want,
  input wire logic       ser_select,
  input wire logic       ser_rd,
  input wire logic       chan_a_clear_clock_pin,
  input wire logic       chan_a_auto_enable,
  input wire logic       chan_a_clear,
  input wire logic       chan_a_clock,
  input wire logic       chan_b_clear,
  input wire logic       chan_b_clock,
  input wire logic       chan_a_tx_enable,
  input wire logic       chain_enable_in,
  input wire logic [8:0] scsi_line_oe
);
  // ==========================================================
  // properties
  // clk_en low freezes all state, so nothing is judged then
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst || !clk_en);
  property p_tx_off;
    (chan_a_auto_enable && chan_a_clear_clock_pin)[*5] |-> !chan_a_tx_enable;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx on with pin high");
  property p_tx_on;
    (!chan_a_auto_enable)[*3] |-> chan_a_tx_enable;
  endproperty
  a_tx_on: assert property (p_tx_on) else $error("tx off without auto enable");
  property p_chain;
    chain_enable_in;
  endproperty
  a_chain: assert property (p_chain) else $error("chain enable dropped");
  property p_pin_hi;
    chan_a_clear_clock_pin[*5] |-> chan_a_clear && chan_a_clock;
  endproperty
  a_pin_hi: assert property (p_pin_hi) else $error("pin high not seen");
  property p_pin_lo;
    (!chan_a_clear_clock_pin)[*5] |-> !chan_a_clear && !chan_a_clock;
  endproperty
  a_pin_lo: assert property (p_pin_lo) else $error("pin low not seen");
  property p_b_pair;
    chan_b_clear == chan_b_clock;
  endproperty
  a_b_pair: assert property (p_b_pair) else $error("pin b copies differ");
  property p_host_oe;
    host_data_oe |-> !$past(rd_n, 3) && !($past(parallel_unit_select_n, 3)
      && $past(serial_unit_select_n, 3) && $past(dma_grant_n, 3));
  endproperty
  a_host_oe: assert property (p_host_oe) else $error("bus driven unselected");
  property p_ser_rd;
    (!serial_unit_select_n && !rd_n && parallel_unit_select_n && dma_grant_n)[*5]
      |-> ser_rd && ser_select;
  endproperty
  a_ser_rd: assert property (p_ser_rd) else $error("serial read not passed");
  property p_dma_clr;
    (!dma_grant_n && !rd_n)[*5] |-> !dma_want;
  endproperty
  a_dma_clr: assert property (p_dma_clr) else $error("grant left request up");
  property p_ack_req;
    !(scsi_line_oe[1] && scsi_line_oe[0]);
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack and req both driven");
  property p_atn_tgt;
    scsi_line_oe[2] |-> !scsi_line_oe[4] && !scsi_line_oe[5];
  endproperty
  a_atn_tgt: assert property (p_atn_tgt) else $error("atn with target lines");
endmodule
bind sshp_core sshp_mon u_mon (.*);
`default_nettype wire

// >>> tb/sshp_tgt_model.sv
// far-side scsi bus partner model, target by default, initiator when ini is set
`timescale 1ns/10ps
`default_nettype none
module sshp_tgt (
  input  wire logic       mclk,
  input  wire logic [8:0] dut_line_oe,
  input  wire logic [7:0] dut_data_oe,
  output wire logic [8:0] line_in,
  output wire logic [7:0] data_in
);
  logic [8:0] drv = 9'h000;
  logic [7:0] dbyte = 8'h00;
  logic       ini = 1'b0;
  logic [7:0] got = 8'h00;
  // terminated bus: a released line floats up to deasserted
  assign line_in = ~(drv | dut_line_oe);
  assign data_in = ~(dbyte | dut_data_oe);
  // req and data are let go once ack shows, no hold beyond
  always @(negedge mclk) begin
    if (drv[0] && dut_line_oe[1]) begin
      drv[0] <= 1'b0;
      dbyte <= 8'h00;
    end
    // playing initiator: ack follows the device's req, byte taken on first req
    if (ini) begin
      drv[1] <= dut_line_oe[0];
      if (dut_line_oe[0] && !drv[1]) begin
        got <= dut_data_oe;
      end
    end
  end
  // ack only while playing initiator, atn never
  task automatic put(input logic [7:0] b, input int dly);
    repeat (dly) @(negedge mclk);
    dbyte = b;
    drv[5] = 1'b1;
    drv[4] = 1'b0;
    drv[0] = 1'b1;
  endtask
  task automatic drop;
    @(negedge mclk);
    drv = 9'h000;
    dbyte = 8'h00;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the scsi host port core
`timescale 1ns/10ps
`default_nettype none
`include "sshp_regs.vh"
module tb_top;
  logic       mclk = 1'b0, srst = 1'b1, clk_en = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
  logic       parallel_unit_select_n = 1'b1, serial_unit_select_n = 1'b1;
  logic       dma_grant_n = 1'b1, transfer_terminate_n = 1'b1;
  logic       chan_a_clear_clock_pin = 1'b1, chan_b_clear_clock_pin = 1'b1;
  logic       chan_a_auto_enable = 1'b0, chan_b_auto_enable = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] host_data_in = 8'h00, ser_rdata = 8'h3C;
  logic [7:0] host_data_out, scsi_data_oe, ser_wdata, q, wd;
  logic [8:0] scsi_line_oe;
  logic [2:0] snap;
  logic       host_data_oe, dma_want, ser_select, ser_rd, ser_wr, chain_enable_in;
  logic       chan_a_clear, chan_a_clock, chan_b_clear, chan_b_clock;
  logic       chan_a_tx_enable, chan_b_tx_enable;
  wire  [7:0] scsi_data_in;
  wire  [8:0] scsi_line_in;
  int         err_count = 0;
  int         comparisons = 0;

  sshp_core dut (.*, .scsi_data_out(), .scsi_parity_out(), .scsi_parity_oe(), .scsi_line_out());
  sshp_tgt tgt (.mclk(mclk), .dut_line_oe(scsi_line_oe), .dut_data_oe(scsi_data_oe),
    .line_in(scsi_line_in), .data_in(scsi_data_in));

  initial begin
    forever #50 mclk = ~mclk;
  end

  // ==========================================================
  // helpers
  task automatic chkb(input logic got, input logic exp, input string m);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  task automatic chkv(input logic [8:0] got, input logic [8:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // who: 0 parallel, 1 serial, 2 grant, 3 none; held past the two sync flops
  task automatic acc(input logic w, input int who, input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk);
    addr = a;
    host_data_in = d;
    parallel_unit_select_n = (who != 0);
    serial_unit_select_n = (who != 1);
    dma_grant_n = (who != 2);
    wr_n = !w;
    rd_n = w;
    repeat (6) @(negedge mclk);
    q = host_data_out;
    wd = ser_wdata;
    snap = {host_data_oe, ser_wr, ser_rd};
    {rd_n, wr_n, parallel_unit_select_n, serial_unit_select_n, dma_grant_n} = 5'h1F;
    repeat (3) @(negedge mclk);
  endtask
  task automatic waitw(input logic v);
    int n;
    n = 0;
    while (dma_want !== v && n < 40) begin
      @(negedge mclk);
      n++;
    end
    if (dma_want !== v) begin
      err_count++;
      $display("FAIL %0t dma request wait ran out", $time);
      complete_run;
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_pins;
    chkb(chain_enable_in, 1'b1, "chain enable");
    chkb(dma_want, 1'b0, "request after reset");
    chan_a_auto_enable = 1'b1;
    repeat (6) @(negedge mclk);
    chkb(chan_a_tx_enable, 1'b0, "tx held off by pin");
    clk_en = 1'b0;
    chan_a_clear_clock_pin = 1'b0;
    chan_b_clear_clock_pin = 1'b0;
    repeat (6) @(negedge mclk);
    chkb(chan_a_tx_enable, 1'b0, "state frozen by clock enable");
    clk_en = 1'b1;
    repeat (6) @(negedge mclk);
    chkb(chan_a_tx_enable, 1'b1, "tx a on by low pin");
    chkb(chan_b_tx_enable, 1'b1, "tx b on by low pin");
    chkv({7'h00, chan_b_clear, chan_b_clock}, 9'h000, "pin b copies");
    chan_a_clear_clock_pin = 1'b1;
    chan_a_auto_enable = 1'b0;
    repeat (6) @(negedge mclk);
    chkv({7'h00, chan_a_clear, chan_a_clock}, 9'h003, "pin a copies");
    $display("test pins done");
  endtask
  task automatic t_regs;
    acc(1'b1, 3, `SSHP_REG_ICMD, 8'h0A);
    chkv(scsi_line_oe, 9'h000, "write without select");
    acc(1'b1, 0, `SSHP_REG_ICMD, 8'h0A);
    chkv(scsi_line_oe, 9'h00C, "atn and bsy driven");
    acc(1'b1, 0, `SSHP_REG_ICMD, 8'h00);
    chkv(scsi_line_oe, 9'h000, "lines released");
    acc(1'b0, 1, 3'h0, 8'h00);
    chkv({1'b0, q}, 9'h03C, "serial read data");
    chkv({6'h00, snap}, 9'h005, "serial read strobes");
    acc(1'b1, 1, `SSHP_REG_ICMD, 8'h5A);
    chkv({1'b0, wd}, 9'h05A, "serial write data");
    chkv({6'h00, snap}, 9'h002, "serial write strobe");
    chkv(scsi_line_oe, 9'h000, "parallel unit untouched");
    acc(1'b1, 0, `SSHP_REG_OUTDATA, 8'h01);
    acc(1'b1, 0, `SSHP_REG_ICMD, 8'h01);
    chkv({1'b0, scsi_data_oe}, 9'h001, "line zero is bit zero");
    tgt.put(8'h80, 0);
    acc(1'b0, 0, `SSHP_REG_BUSDATA, 8'h00);
    chkv({1'b0, q}, 9'h081, "bus data read");
    tgt.drop;
    acc(1'b1, 0, `SSHP_REG_ICMD, 8'h00);
    $display("test registers done");
  endtask
  task automatic t_dma;
    tgt.put(8'h5C, 0);
    repeat (10) @(negedge mclk);
    chkb(dma_want, 1'b0, "no request outside dma mode");
    tgt.drop;
    acc(1'b1, 0, `SSHP_REG_MODE, 8'h02);
    tgt.put(8'hA5, 4);
    waitw(1'b1);
    acc(1'b0, 2, `SSHP_REG_OUTDATA, 8'h00);
    chkv({1'b0, q}, 9'h0A5, "grant read takes input data");
    chkb(dma_want, 1'b0, "grant clears request");
    chkb(tgt.drv[0], 1'b0, "ack answered request");
    chkv(scsi_line_oe, 9'h000, "ack released");
    tgt.put(8'h3E, 0);
    waitw(1'b1);
    transfer_terminate_n = 1'b0;
    acc(1'b0, 2, 3'h0, 8'h00);
    transfer_terminate_n = 1'b1;
    chkv({1'b0, q}, 9'h03E, "last byte moved");
    tgt.put(8'h3F, 0);
    repeat (12) @(negedge mclk);
    chkb(dma_want, 1'b0, "no request after terminate");
    tgt.drop;
    acc(1'b1, 0, `SSHP_REG_MODE, 8'h00);
    $display("test dma done");
  endtask
  task automatic t_target;
    tgt.ini = 1'b1;
    acc(1'b1, 0, `SSHP_REG_MODE, 8'h42);
    acc(1'b1, 0, `SSHP_REG_TCMD, 8'h03);
    chkv(scsi_line_oe, 9'h030, "target drives io and c/d");
    chkb(dma_want, 1'b1, "target requests in dma mode");
    acc(1'b1, 2, 3'h0, 8'h96);
    chkv({1'b0, tgt.got}, 9'h096, "grant write sent output data");
    chkv(scsi_line_oe, 9'h030, "req dropped on ack");
    waitw(1'b1);
    acc(1'b1, 0, `SSHP_REG_MODE, 8'h00);
    acc(1'b1, 0, `SSHP_REG_TCMD, 8'h00);
    tgt.ini = 1'b0;
    chkv(scsi_line_oe, 9'h000, "target lines released");
    chkb(dma_want, 1'b0, "request gone with dma mode");
    $display("test target done");
  endtask

  initial begin
    repeat (16) @(negedge mclk);
    srst = 1'b0;
    repeat (4) @(negedge mclk);
    t_pins;
    t_regs;
    t_dma;
    t_target;
    complete_run;
  end
endmodule
`default_nettype wire
